// ===== logic/raid0_stripe_data_switch.sv
`timescale 1ns/10ps
`include "raid0_switch_defs.svh"

module raid0_stripe_data_switch #(
    parameter logic [15:0] CHAN_DEPTH = `CHAN_DEPTH_DEF,
    parameter logic [15:0] USER_DEPTH = `USER_DEPTH_DEF
) (
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    input  wire logic                  clk_en,
    input  wire logic                  op_start,
    input  wire logic                  op_read,
    input  wire logic [`LEN_W-1:0]     op_len,
    input  wire logic                  op_addr_lsb,
    output logic                       op_busy,
    output logic                       op_done,
    input  wire logic [`LEVEL_W-1:0]   user_tx_fifo_level,
    output logic                       user_tx_fifo_pop,
    input  wire logic [`WORD_W-1:0]    user_tx_fifo_word,
    input  wire logic [`LEVEL_W-1:0]   user_rx_fifo_level,
    output logic                       user_rx_fifo_push,
    output logic [`WORD_W-1:0]         user_rx_fifo_data,
    input  wire logic [2*`LEVEL_W-1:0] chan_tx_fifo_level,
    output logic [1:0]                 chan_tx_fifo_push,
    output logic [`WORD_W-1:0]         chan_tx_fifo_data,
    input  wire logic [2*`LEVEL_W-1:0] chan_rx_fifo_level,
    output logic [1:0]                 chan_rx_fifo_pop,
    input  wire logic [2*`WORD_W-1:0]  chan_rx_fifo_word,
    input  wire logic [1:0]            chan_busy
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    raid0_switch_pkg::switch_state_type state_q;
    raid0_switch_pkg::switch_state_type state_d;

    logic [3:0]              beat_q;
    logic [1:0]              settle_q;
    logic [`LEN_W-1:0]       remain_q;
    logic                    read_mode_q;
    logic                    active_channel_select;
    logic                    next_channel_select;
    logic                    mux_chan_q;
    logic                    mux_read_q;
    logic [`LEVEL_W-1:0]     chan_level_q;
    logic                    sel_d1_q;
    logic                    sel_d2_q;
    logic                    wr_d1_q;
    logic                    wr_d2_q;
    logic                    rd_d1_q;
    logic                    rd_d2_q;
    logic                    done_q;
    logic [`WORD_W-1:0]      tx_word_q;
    logic [2*`WORD_W-1:0]    rx_stage_q;
    logic [`WORD_W-1:0]      rx_word_q;
    logic                    rx_push_q;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire in_idle     = (state_q == raid0_switch_pkg::ST_IDLE);
    wire in_central  = (state_q == raid0_switch_pkg::ST_CENTRAL);
    wire in_transfer = (state_q == raid0_switch_pkg::ST_TRANSFER);
    wire in_settle   = (state_q == raid0_switch_pkg::ST_SETTLE);
    wire in_end      = (state_q == raid0_switch_pkg::ST_END);
    wire last_beat   = in_transfer && (beat_q == `LAST_BEAT);
    wire take_start  = in_idle && op_start;

    // registered level only counts once it belongs to this channel/mode
    wire level_fresh = (mux_chan_q == active_channel_select) &&
                       (mux_read_q == read_mode_q);

    wire [`LEVEL_W-1:0] tx_lvl_next = next_channel_select ?
        chan_tx_fifo_level[2*`LEVEL_W-1:`LEVEL_W] :
        chan_tx_fifo_level[`LEVEL_W-1:0];
    wire [`LEVEL_W-1:0] rx_lvl_next = next_channel_select ?
        chan_rx_fifo_level[2*`LEVEL_W-1:`LEVEL_W] :
        chan_rx_fifo_level[`LEVEL_W-1:0];

    wire wr_ready = level_fresh &&
        (user_tx_fifo_level >= `STRIPE_WORDS) &&
        (chan_level_q <= CHAN_DEPTH - `TWO_STRIPES);
    wire rd_ready = level_fresh && (remain_q != '0) &&
        (chan_level_q >= `STRIPE_WORDS) &&
        (user_rx_fifo_level <= USER_DEPTH - `TWO_STRIPES);

    wire remain_last = (remain_q == `LEN_W'h1);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            raid0_switch_pkg::ST_IDLE: begin
                if (op_start) begin
                    state_d = raid0_switch_pkg::ST_CENTRAL;
                end
            end
            raid0_switch_pkg::ST_CENTRAL: begin
                if (!read_mode_q) begin
                    if (remain_q == '0) begin
                        state_d = raid0_switch_pkg::ST_IDLE;
                    end else if (wr_ready) begin
                        state_d = raid0_switch_pkg::ST_TRANSFER;
                    end
                end else if (remain_q == '0) begin
                    state_d = raid0_switch_pkg::ST_END;
                end else if (rd_ready) begin
                    state_d = raid0_switch_pkg::ST_TRANSFER;
                end
            end
            raid0_switch_pkg::ST_TRANSFER: begin
                if (beat_q == `LAST_BEAT) begin
                    if (read_mode_q) begin
                        state_d = remain_last ?
                            raid0_switch_pkg::ST_END :
                            raid0_switch_pkg::ST_CENTRAL;
                    end else begin
                        // level still shrinking here, so two stripes
                        // means one is certainly left
                        state_d = (user_tx_fifo_level >= `TWO_STRIPES) ?
                            raid0_switch_pkg::ST_CENTRAL :
                            raid0_switch_pkg::ST_SETTLE;
                    end
                end
            end
            raid0_switch_pkg::ST_SETTLE: begin
                if (settle_q == `SETTLE_LAST) begin
                    state_d = raid0_switch_pkg::ST_CENTRAL;
                end
            end
            raid0_switch_pkg::ST_END: begin
                if (chan_busy == 2'h0) begin
                    state_d = raid0_switch_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = raid0_switch_pkg::ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q  <= raid0_switch_pkg::ST_IDLE;
            beat_q   <= 4'h0;
            settle_q <= 2'h0;
            done_q   <= 1'b0;
        end else if (clk_en) begin
            state_q  <= state_d;
            beat_q   <= in_transfer ? beat_q + 4'h1 : 4'h0;
            settle_q <= in_settle ? settle_q + 2'h1 : 2'h0;
            done_q   <= !in_idle &&
                        (state_d == raid0_switch_pkg::ST_IDLE);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            remain_q    <= '0;
            read_mode_q <= 1'b0;
        end else if (clk_en) begin
            if (take_start) begin
                remain_q    <= op_len;
                read_mode_q <= op_read;
            end else if (last_beat) begin
                remain_q    <= remain_q - `LEN_W'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // channel selects
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            active_channel_select <= 1'b0;
            next_channel_select   <= 1'b0;
        end else if (clk_en) begin
            if (take_start) begin
                active_channel_select <= op_addr_lsb;
                next_channel_select   <= op_addr_lsb;
            end else if (in_transfer) begin
                // look ahead so the level is settled by the next wait
                next_channel_select <= ~active_channel_select;
                if (last_beat) begin
                    active_channel_select <= ~active_channel_select;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            chan_level_q <= '0;
            mux_chan_q   <= 1'b0;
            mux_read_q   <= 1'b0;
        end else if (clk_en) begin
            chan_level_q <= read_mode_q ? rx_lvl_next : tx_lvl_next;
            mux_chan_q   <= next_channel_select;
            mux_read_q   <= read_mode_q;
        end
    end

    // ------------------------------------------------------------
    // data pipeline
    // ------------------------------------------------------------
    assign user_tx_fifo_pop = clk_en && in_transfer && !read_mode_q;
    assign chan_rx_fifo_pop = {2{clk_en && in_transfer && read_mode_q}} &
        (active_channel_select ? 2'h2 : 2'h1);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sel_d1_q <= 1'b0;
            sel_d2_q <= 1'b0;
            wr_d1_q  <= 1'b0;
            wr_d2_q  <= 1'b0;
            rd_d1_q  <= 1'b0;
            rd_d2_q  <= 1'b0;
        end else if (clk_en) begin
            sel_d1_q <= active_channel_select;
            sel_d2_q <= sel_d1_q;
            wr_d1_q  <= user_tx_fifo_pop;
            wr_d2_q  <= wr_d1_q;
            rd_d1_q  <= |chan_rx_fifo_pop;
            rd_d2_q  <= rd_d1_q;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_word_q  <= '0;
            rx_stage_q <= '0;
            rx_word_q  <= '0;
            rx_push_q  <= 1'b0;
        end else if (clk_en) begin
            if (wr_d1_q) begin
                tx_word_q <= user_tx_fifo_word;
            end
            if (rd_d1_q) begin
                rx_stage_q <= chan_rx_fifo_word;
            end
            if (rd_d2_q) begin
                rx_word_q <= sel_d2_q ?
                    rx_stage_q[2*`WORD_W-1:`WORD_W] :
                    rx_stage_q[`WORD_W-1:0];
            end
            rx_push_q <= rd_d2_q;
        end
    end

    // pushes are gated so a frozen clock never writes twice
    assign chan_tx_fifo_push = {2{clk_en && wr_d2_q}} &
        (sel_d2_q ? 2'h2 : 2'h1);
    assign chan_tx_fifo_data = tx_word_q;
    assign user_rx_fifo_push = clk_en && rx_push_q;
    assign user_rx_fifo_data = rx_word_q;
    assign op_busy           = !in_idle;
    assign op_done           = clk_en && done_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk iff clk_en);
    endclocking
    default disable iff (!rst_n);

    // burst length kept in a counter, the tools choke on long repeats
    logic [`LEVEL_W-1:0] pop_run_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pop_run_q <= '0;
        end else if (clk_en) begin
            pop_run_q <= user_tx_fifo_pop ? pop_run_q + `LEVEL_W'h1 : '0;
        end
    end

    sequence wr_burst_s;
        !user_tx_fifo_pop && pop_run_q == `STRIPE_WORDS;
    endsequence

    sequence settle_s;
        in_settle [*3] ##1 in_central;
    endsequence

    a_wr_pop_burst: assert property (
        $fell(user_tx_fifo_pop) |-> wr_burst_s)
        else $error("write pop burst not sixteen cycles");
    a_wr_pop_cap: assert property (
        user_tx_fifo_pop |-> pop_run_q < `STRIPE_WORDS)
        else $error("write pop burst longer than sixteen");
    a_rx_pop_active: assert property (
        |chan_rx_fifo_pop |->
        chan_rx_fifo_pop == (active_channel_select ? 2'h2 : 2'h1))
        else $error("read pop on inactive channel");
    a_tx_push_route: assert property (
        user_tx_fifo_pop |-> ##2
        chan_tx_fifo_push == ($past(active_channel_select, 2) ?
                              2'h2 : 2'h1))
        else $error("write data sent to wrong channel");
    a_rx_data_route: assert property (
        chan_rx_fifo_pop[0] |-> ##3 user_rx_fifo_push &&
        user_rx_fifo_data == $past(chan_rx_fifo_word[`WORD_W-1:0], 2))
        else $error("read data not from channel zero");
    a_chan_rotate: assert property (
        last_beat |=> active_channel_select != $past(active_channel_select))
        else $error("active channel did not rotate");
    a_next_sel: assert property (
        in_transfer |=> next_channel_select == !$past(active_channel_select))
        else $error("next channel not derived from active");
    a_settle_len: assert property (
        $rose(in_settle) |-> settle_s)
        else $error("settle state not three cycles");
    a_wr_gate: assert property (
        in_central ##1 (in_transfer && !read_mode_q) |->
        $past(user_tx_fifo_level) >= `STRIPE_WORDS &&
        (active_channel_select ?
         $past(chan_tx_fifo_level[2*`LEVEL_W-1:`LEVEL_W], 2) :
         $past(chan_tx_fifo_level[`LEVEL_W-1:0], 2)) <=
        CHAN_DEPTH - `TWO_STRIPES)
        else $error("write started without a stripe");
    a_write_done: assert property (
        in_central && !read_mode_q && remain_q == '0 |=> in_idle ##1 1'b1)
        else $error("write did not end at zero length");
    a_end_busy: assert property (
        in_end && chan_busy != 2'h0 |=> in_end)
        else $error("end wait left while a channel busy");
    a_wr_next_pick: assert property (
        last_beat && !read_mode_q && user_tx_fifo_level < `TWO_STRIPES
        |=> in_settle)
        else $error("short user level did not settle");

endmodule : raid0_stripe_data_switch

// ===== shared/raid0_switch_defs.svh
`ifndef RAID0_SWITCH_DEFS_SVH
`define RAID0_SWITCH_DEFS_SVH

`define WORD_W          256
`define LEVEL_W         16
`define LEN_W           48
`define STRIPE_WORDS    16'h0010
`define TWO_STRIPES     16'h0020
`define LAST_BEAT       4'hF
`define SETTLE_LAST     2'h2
`define CHAN_DEPTH_DEF  16'h0400
`define USER_DEPTH_DEF  16'h0400

`endif

// ===== shared/raid0_switch_pkg.sv
package raid0_switch_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CENTRAL,
        ST_TRANSFER,
        ST_SETTLE,
        ST_END
    } switch_state_type;

endpackage : raid0_switch_pkg

// ===== testbench/stripe_fifo_model.sv
`timescale 1ns/10ps
`include "raid0_switch_defs.svh"

module stripe_fifo_model #(
    parameter int DEPTH = 64
) (
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    input  wire logic                 clk_en,
    input  wire logic                 feed,
    input  wire logic                 drain,
    input  wire logic                 user_tx_fifo_pop,
    input  wire logic                 user_rx_fifo_push,
    input  wire logic [1:0]           chan_tx_fifo_push,
    input  wire logic [1:0]           chan_rx_fifo_pop,
    output logic [`LEVEL_W-1:0]       user_tx_fifo_level,
    output logic [`WORD_W-1:0]        user_tx_fifo_word,
    output logic [`LEVEL_W-1:0]       user_rx_fifo_level,
    output logic [2*`LEVEL_W-1:0]     chan_tx_fifo_level,
    output logic [2*`LEVEL_W-1:0]     chan_rx_fifo_level,
    output logic [2*`WORD_W-1:0]      chan_rx_fifo_word
);
    logic [31:0] tx_seq_q;
    logic [30:0] rx_seq_q [2];

    // ------------------------------------------------------------
    // fifo levels and read data
    // ------------------------------------------------------------
    // read data is only good in the cycle after a pop; otherwise the
    // bus flips so a late sample never sees a stale word; the fifos
    // share the block's enable, so a frozen cycle holds every word
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_seq_q <= '0;
            rx_seq_q <= '{default: '0};
            user_tx_fifo_level <= '0;
            user_tx_fifo_word <= '0;
            user_rx_fifo_level <= '0;
            chan_tx_fifo_level <= '0;
            chan_rx_fifo_level <= '0;
            chan_rx_fifo_word <= '0;
        end else if (clk_en) begin
            user_tx_fifo_level <= user_tx_fifo_level
                + 16'(feed && user_tx_fifo_level < DEPTH)
                - 16'(user_tx_fifo_pop);
            user_rx_fifo_level <= user_rx_fifo_level
                + 16'(user_rx_fifo_push)
                - 16'(drain && user_rx_fifo_level != 0);
            if (user_tx_fifo_pop) begin
                user_tx_fifo_word <= {8{tx_seq_q}};
                tx_seq_q <= tx_seq_q + 1;
            end else begin
                user_tx_fifo_word <= ~user_tx_fifo_word;
            end
            for (int c = 0; c < 2; c++) begin
                chan_rx_fifo_level[c*16 +: 16] <=
                    chan_rx_fifo_level[c*16 +: 16]
                    + 16'(feed && chan_rx_fifo_level[c*16 +: 16] < DEPTH)
                    - 16'(chan_rx_fifo_pop[c]);
                chan_tx_fifo_level[c*16 +: 16] <=
                    chan_tx_fifo_level[c*16 +: 16]
                    + 16'(chan_tx_fifo_push[c])
                    - 16'(drain && chan_tx_fifo_level[c*16 +: 16] != 0);
                if (chan_rx_fifo_pop[c]) begin
                    chan_rx_fifo_word[c*256 +: 256] <=
                        {8{1'(c), rx_seq_q[c]}};
                    rx_seq_q[c] <= rx_seq_q[c] + 1;
                end else begin
                    chan_rx_fifo_word[c*256 +: 256] <=
                        ~chan_rx_fifo_word[c*256 +: 256];
                end
            end
        end
    end
endmodule : stripe_fifo_model

// ===== testbench/test_raid0_stripe_data_switch.sv
`timescale 1ns/10ps
`include "raid0_switch_defs.svh"

`define CHK(what, got, exp) begin checks_done++; if ((got) !== (exp)) begin \
    error_cnt++; $display("wrong value %s exp %0h got %0h", what, exp, got); \
    end end

module test_raid0_stripe_data_switch;
    localparam logic [15:0] DEPTH = 16'h0040;
    logic mclk, rst_n, clk_en, op_start, op_read, op_addr_lsb, op_busy;
    logic op_done, feed, drain, user_tx_fifo_pop, user_rx_fifo_push;
    logic [`LEN_W-1:0] op_len;
    logic [`LEVEL_W-1:0] user_tx_fifo_level, user_rx_fifo_level;
    logic [`WORD_W-1:0] user_tx_fifo_word, user_rx_fifo_data, chan_tx_fifo_data;
    logic [2*`LEVEL_W-1:0] chan_tx_fifo_level, chan_rx_fifo_level;
    logic [1:0] chan_tx_fifo_push, chan_rx_fifo_pop, chan_busy;
    logic [2*`WORD_W-1:0] chan_rx_fifo_word;
    logic [`WORD_W-1:0] data_q [$];
    logic ch_q [$];
    logic stripe_q [$];
    logic [31:0] wseq = 0;
    logic [30:0] rseq [2] = '{default: '0};
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    int run = 0;
    logic pop_was = 0;

    raid0_stripe_data_switch #(.CHAN_DEPTH(DEPTH), .USER_DEPTH(DEPTH))
    raid0_stripe_data_switch_inst (.mclk(mclk), .rst_n(rst_n),
        .clk_en(clk_en), .op_start(op_start), .op_read(op_read),
        .op_len(op_len), .op_addr_lsb(op_addr_lsb), .op_busy(op_busy),
        .op_done(op_done), .user_tx_fifo_level(user_tx_fifo_level),
        .user_tx_fifo_pop(user_tx_fifo_pop),
        .user_tx_fifo_word(user_tx_fifo_word),
        .user_rx_fifo_level(user_rx_fifo_level),
        .user_rx_fifo_push(user_rx_fifo_push),
        .user_rx_fifo_data(user_rx_fifo_data),
        .chan_tx_fifo_level(chan_tx_fifo_level),
        .chan_tx_fifo_push(chan_tx_fifo_push),
        .chan_tx_fifo_data(chan_tx_fifo_data),
        .chan_rx_fifo_level(chan_rx_fifo_level),
        .chan_rx_fifo_pop(chan_rx_fifo_pop),
        .chan_rx_fifo_word(chan_rx_fifo_word), .chan_busy(chan_busy));

    stripe_fifo_model #(.DEPTH(64)) stripe_fifo_model_inst (.mclk(mclk),
        .rst_n(rst_n), .clk_en(clk_en), .feed(feed), .drain(drain),
        .user_tx_fifo_pop(user_tx_fifo_pop),
        .user_rx_fifo_push(user_rx_fifo_push),
        .chan_tx_fifo_push(chan_tx_fifo_push),
        .chan_rx_fifo_pop(chan_rx_fifo_pop),
        .user_tx_fifo_level(user_tx_fifo_level),
        .user_tx_fifo_word(user_tx_fifo_word),
        .user_rx_fifo_level(user_rx_fifo_level),
        .chan_tx_fifo_level(chan_tx_fifo_level),
        .chan_rx_fifo_level(chan_rx_fifo_level),
        .chan_rx_fifo_word(chan_rx_fifo_word));

    always #2 mclk = ~mclk;

    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------
    // driver: notes every expected word, then runs one operation
    // ------------------------------------------------------------
    task automatic run_op(input logic rd, input logic [`LEN_W-1:0] len);
        logic lsb;
        logic ch;
        lsb = 1'($urandom);
        for (int k = 0; k < int'(len); k++) begin
            ch = lsb ^ k[0];
            stripe_q.push_back(ch);
            for (int j = 0; j < 16; j++) begin
                ch_q.push_back(ch);
                data_q.push_back(rd ? {8{ch, rseq[ch]}} : {8{wseq}});
                if (rd) rseq[ch]++;
                else wseq++;
            end
        end
        op_read <= rd;
        op_len <= len;
        op_addr_lsb <= lsb;
        op_start <= 1'b1;
        chan_busy <= {rd, rd};
        // start stays high one edge past busy: that edge must be ignored
        while (op_busy !== 1'b1) @(posedge mclk);
        op_start <= 1'b0;
        if (rd) begin
            while (data_q.size() != 0) @(posedge mclk);
            repeat (6) @(posedge mclk);
            chan_busy <= 2'b10;
            repeat (4) @(posedge mclk);
            chan_busy <= 2'b00;
        end
        while (op_done !== 1'b1) @(posedge mclk);
        repeat (4) @(posedge mclk);
        `CHK("words left", data_q.size(), 0)
    endtask : run_op

    // ------------------------------------------------------------
    // monitor: compares each result with the oldest note
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        logic pop_now;
        logic ch;
        pop_now = user_tx_fifo_pop | (|chan_rx_fifo_pop);
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            complete_run();
        end
        if (rst_n && (chan_tx_fifo_push != 2'b00 || user_rx_fifo_push)) begin
            if (data_q.size() == 0) `CHK("extra word", 1'b1, 1'b0)
            else begin
                if (user_rx_fifo_push) `CHK("rx word", user_rx_fifo_data, data_q[0])
                else `CHK("tx word", chan_tx_fifo_data, data_q[0])
                if (!user_rx_fifo_push) `CHK("tx push", chan_tx_fifo_push, 2'b01 << ch_q[0])
                void'(data_q.pop_front());
                void'(ch_q.pop_front());
            end
        end
        if (rst_n && clk_en && pop_now && !pop_was) begin
            ch = (stripe_q.size() != 0) ? stripe_q.pop_front() : 1'b0;
            if (op_read) begin
                `CHK("rx pop", chan_rx_fifo_pop, 2'b01 << ch)
                `CHK("rx held", chan_rx_fifo_level[ch*16 +: 16] >= 16, 1'b1)
                `CHK("user room", user_rx_fifo_level <= DEPTH - 16, 1'b1)
            end else begin
                `CHK("tx room", chan_tx_fifo_level[ch*16 +: 16] <= DEPTH - 32, 1'b1)
                `CHK("tx held", user_tx_fifo_level >= 16, 1'b1)
            end
            run = 0;
        end
        if (clk_en && pop_now) run++;
        if (rst_n && clk_en && !pop_now && pop_was)
            `CHK("pop run", run, 16)
        if (rst_n && op_done) `CHK("busy at end", chan_busy, 2'b00)
        // a frozen cycle is no gap in a burst
        if (clk_en) pop_was = pop_now;
        clk_en <= ($urandom % 8) != 0;
        feed <= ($urandom % 4) != 0;
        drain <= 1'($urandom);
    end

    initial begin
        logic [31:0] seed;
        mclk = 0;
        rst_n = 0;
        clk_en = 1;
        op_start = 0;
        op_read = 0;
        op_len = '0;
        op_addr_lsb = 0;
        chan_busy = 2'b00;
        feed = 0;
        drain = 0;
        seed = $urandom(32'hECE0330E);
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        @(posedge mclk);
        `CHK("idle busy", op_busy, 1'b0)
        `CHK("idle pops", {user_tx_fifo_pop, chan_rx_fifo_pop}, 3'h0)
        // two empty operations first, then alternating write and read
        for (int i = 0; i < 10; i++) begin
            run_op(i[0], (i < 2) ? '0 : `LEN_W'(1 + $urandom % 4));
            $display("test %0d done", i);
        end
        complete_run();
    end
endmodule : test_raid0_stripe_data_switch
